/* File: verilog/flash_guard_regs.svh */
`ifndef FLASH_GUARD_REGS_SVH
`define FLASH_GUARD_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_LOCK_LO 8'h10
`define OFS_LOCK_HI 8'h14
`define OFS_IRQ_EN 8'h20
`define OFS_IRQ_FLAGS 8'h24
`define OFS_IRQ_CLR 8'h28

// ----------------------------------------
// fields and values
// ----------------------------------------
`define UNLOCK_KEY 16'h5A5A
`define KEY_HI 31
`define KEY_LO 16
`define BIT_NONBLANK 4
`define BIT_GUARD 1
`define BIT_EXEC 0
`define FLAG_MASK 5'h13
`define LOCK_RESET 16'h0000
`define IRQ_EN_RESET 5'h00
`define IRQ_FLAGS_RESET 5'h00
`define IRQ_CLR_RESET 32'h0000001F
`define BLANK_BYTE 8'hFF

`endif

/* File: verilog/flash_guard_pkg.sv */
package flash_guard_pkg;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROGRAM = 2'b01,
    OP_PAGE_ERASE = 2'b10,
    OP_CHIP_ERASE = 2'b11
  } op_mode_e;

  typedef struct packed {
    logic [15:0] lock_lo;
    logic [15:0] lock_hi;
    logic [4:0] irq_en;
    logic [4:0] flags;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic op_go;
    logic op_refused;
    logic irq;
  } state_s;

endpackage : flash_guard_pkg

/* File: verilog/group_guard.sv */
module group_guard #(
  parameter int GROUPS = 32
) (
  // target page and lock bits
  input wire logic [8:0] page,
  input wire logic [GROUPS-1:0] lock_bits,
  // decode
  output logic page_locked,
  output logic any_locked
);

  logic [GROUPS-1:0] hit;

  // ----------------------------------------
  // one comparator per 8-page group
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < GROUPS; i++) begin : g_grp
      assign hit[i] = page[8] && (page[7:3] == 5'(i)) && !lock_bits[i];
    end
  endgenerate

  assign page_locked = |hit;
  assign any_locked = !(&lock_bits);

endmodule : group_guard

/* File: verilog/flash_guard.sv */
// Design decision made here: register access over APB.
`include "flash_guard_regs.svh"

module flash_guard (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operation request from sequencer
  input wire logic op_req,
  input wire logic [1:0] op_mode,
  input wire logic [8:0] op_page,
  input wire logic [8:0] exec_page,
  input wire logic [31:0] cur_word,
  // operation verdict
  output logic op_go,
  output logic op_refused,
  // interrupt
  output logic irq
);

  flash_guard_pkg::state_s cur_ff;
  flash_guard_pkg::state_s nxt_st;

  logic page_locked;
  logic any_locked;
  logic [3:0] byte_blank;
  logic is_program;
  logic is_erase;
  logic is_chip;
  logic guard_hit;
  logic exec_hit;
  logic nonblank;
  logic [4:0] ev_set;
  logic [4:0] clr_bits;
  logic acc;
  logic wr_en;
  logic key_ok;
  logic mapped;
  logic [4:0] pend;

  // ----------------------------------------
  // group lookup
  // ----------------------------------------
  group_guard #(
    .GROUPS(32)
  ) u_guard (
    .page(op_page),
    .lock_bits({cur_ff.lock_hi, cur_ff.lock_lo}),
    .page_locked(page_locked),
    .any_locked(any_locked)
  );

  // ----------------------------------------
  // blank check per byte
  // ----------------------------------------
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_byte
      assign byte_blank[b] = cur_word[8*b +: 8] == `BLANK_BYTE;
    end
  endgenerate

  // ----------------------------------------
  // operation classification
  // ----------------------------------------
  always_comb begin
    is_program = op_mode == flash_guard_pkg::OP_PROGRAM;
    is_chip = op_mode == flash_guard_pkg::OP_CHIP_ERASE;
    is_erase = op_mode == flash_guard_pkg::OP_PAGE_ERASE || is_chip;
    guard_hit = (is_program || is_erase) && (is_chip ? any_locked : page_locked);
    exec_hit = (is_program || is_erase) && (is_chip || op_page == exec_page);
    nonblank = is_program && !(&byte_blank);
    ev_set = '0;
    ev_set[`BIT_NONBLANK] = op_req && nonblank;
    ev_set[`BIT_GUARD] = op_req && guard_hit;
    ev_set[`BIT_EXEC] = op_req && exec_hit;
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  always_comb begin
    acc = psel && penable && !cur_ff.pready;
    wr_en = psel && penable && cur_ff.pready && pwrite && !cur_ff.pslverr;
    key_ok = pwdata[`KEY_HI:`KEY_LO] == `UNLOCK_KEY;
    case (paddr)
      `OFS_LOCK_LO, `OFS_LOCK_HI, `OFS_IRQ_EN, `OFS_IRQ_FLAGS, `OFS_IRQ_CLR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    clr_bits = '0;
    if (wr_en && paddr == `OFS_IRQ_CLR) begin
      clr_bits = ~pwdata[4:0] & `FLAG_MASK;
    end
    pend = cur_ff.flags & cur_ff.irq_en;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.pready = acc;
    nxt_st.pslverr = acc && !mapped;
    if (acc && !pwrite) begin
      case (paddr)
        `OFS_LOCK_LO: nxt_st.prdata = {16'h0000, cur_ff.lock_lo};
        `OFS_LOCK_HI: nxt_st.prdata = {16'h0000, cur_ff.lock_hi};
        `OFS_IRQ_EN: nxt_st.prdata = {27'h0000000, cur_ff.irq_en};
        `OFS_IRQ_FLAGS: nxt_st.prdata = {27'h0000000, cur_ff.flags};
        `OFS_IRQ_CLR: nxt_st.prdata = `IRQ_CLR_RESET;
        default: nxt_st.prdata = 32'h00000000;
      endcase
    end else if (acc) begin
      nxt_st.prdata = 32'h00000000;
    end
    if (wr_en && paddr == `OFS_LOCK_LO && key_ok) begin
      nxt_st.lock_lo = pwdata[15:0];
    end
    if (wr_en && paddr == `OFS_LOCK_HI && key_ok) begin
      nxt_st.lock_hi = pwdata[15:0];
    end
    if (wr_en && paddr == `OFS_IRQ_EN) begin
      nxt_st.irq_en = pwdata[4:0] & `FLAG_MASK;
    end
    // set wins over clear
    nxt_st.flags = (cur_ff.flags & ~clr_bits) | ev_set;
    nxt_st.op_go = op_req && (ev_set == 5'h00);
    nxt_st.op_refused = op_req && (ev_set != 5'h00);
    nxt_st.irq = |pend;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '{
        lock_lo: `LOCK_RESET,
        lock_hi: `LOCK_RESET,
        irq_en: `IRQ_EN_RESET,
        flags: `IRQ_FLAGS_RESET,
        prdata: 32'h00000000,
        pready: 1'b0,
        pslverr: 1'b0,
        op_go: 1'b0,
        op_refused: 1'b0,
        irq: 1'b0
      };
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign op_go = cur_ff.op_go;
  assign op_refused = cur_ff.op_refused;
  assign irq = cur_ff.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_key_guard_lo: assert property (
    wr_en && paddr == `OFS_LOCK_LO && !key_ok |=> cur_ff.lock_lo == $past(cur_ff.lock_lo))
    else $error("lock register changed without key");

  a_key_take_hi: assert property (
    wr_en && paddr == `OFS_LOCK_HI && key_ok |=> cur_ff.lock_hi == $past(pwdata[15:0]))
    else $error("keyed lock write not taken");

  a_group_low: assert property (
    op_req && op_mode == 2'b10 && op_page[8:7] == 2'b10 && !cur_ff.lock_lo[op_page[6:3]]
    |=> cur_ff.flags[`BIT_GUARD] && cur_ff.op_refused && !cur_ff.op_go)
    else $error("locked low group not refused");

  a_group_high: assert property (
    op_req && op_mode == 2'b10 && op_page[8:7] == 2'b11 && !cur_ff.lock_hi[op_page[6:3]]
    |=> cur_ff.flags[`BIT_GUARD] && !cur_ff.op_go)
    else $error("locked high group not refused");

  a_open_pass: assert property (
    op_req && op_mode == 2'b10 && op_page[8] && op_page != exec_page
    && (op_page[7] ? cur_ff.lock_hi[op_page[6:3]] : cur_ff.lock_lo[op_page[6:3]])
    |=> cur_ff.op_go)
    else $error("open group erase refused");

  a_nonblank_flag: assert property (
    op_req && op_mode == 2'b01 && cur_word != 32'hFFFFFFFF
    |=> cur_ff.flags[`BIT_NONBLANK] && cur_ff.op_refused)
    else $error("nonblank program not flagged");

  a_exec_flag: assert property (
    op_req && op_mode == 2'b10 && op_page == exec_page
    |=> cur_ff.flags[`BIT_EXEC] ##1 (irq || !$past(cur_ff.irq_en[`BIT_EXEC])))
    else $error("executing page erase not flagged");

  a_clear_zero: assert property (
    wr_en && paddr == `OFS_IRQ_CLR && !pwdata[`BIT_NONBLANK] && !op_req
    |=> !cur_ff.flags[`BIT_NONBLANK])
    else $error("programming error flag not cleared");

  a_clear_one: assert property (
    wr_en && paddr == `OFS_IRQ_CLR && pwdata[`BIT_GUARD] && cur_ff.flags[`BIT_GUARD]
    |=> cur_ff.flags[`BIT_GUARD])
    else $error("writing one cleared a flag");

  a_clr_read: assert property (
    acc && !pwrite && paddr == `OFS_IRQ_CLR |=> prdata == 32'h0000001F)
    else $error("clear register read wrong");

  a_irq_level: assert property (
    ##1 irq == ($past(cur_ff.flags & cur_ff.irq_en) != 5'h00))
    else $error("interrupt level mismatch");

  a_apb_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  // ----------------------------------------
  // register bus checks
  // ----------------------------------------
  a_pready_idle: assert property (
    !psel
    |=> !pready)
    else $error("answer without a select");

  a_unmapped_err: assert property (
    acc && !mapped
    |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");

  a_write_rdata: assert property (
    acc && pwrite
    |=> prdata == 32'h00000000)
    else $error("read data not zero on write");

  a_key_guard_hi: assert property (
    wr_en && paddr == `OFS_LOCK_HI && !key_ok
    |=> cur_ff.lock_hi == $past(cur_ff.lock_hi))
    else $error("high lock register changed without key");

  a_key_take_lo: assert property (
    wr_en && paddr == `OFS_LOCK_LO && key_ok
    |=> cur_ff.lock_lo == $past(pwdata[15:0]))
    else $error("keyed low lock write not taken");

  a_enable_take: assert property (
    wr_en && paddr == `OFS_IRQ_EN
    |=> cur_ff.irq_en == ($past(pwdata[4:0]) & `FLAG_MASK))
    else $error("enable write not taken");

  // ----------------------------------------
  // operation checks
  // ----------------------------------------
  a_low_open: assert property (
    op_req && op_mode == 2'h2 && !op_page[8] && op_page != exec_page
    |=> cur_ff.op_go)
    else $error("erase below guarded range refused");

  a_blank_go: assert property (
    op_req && op_mode == 2'h1 && cur_word == 32'hFFFFFFFF && !op_page[8] && op_page != exec_page
    |=> cur_ff.op_go)
    else $error("blank program refused");

  a_read_go: assert property (
    op_req && op_mode == 2'h0
    |=> cur_ff.op_go && !cur_ff.op_refused)
    else $error("read operation refused");

  a_chip_refused: assert property (
    op_req && op_mode == 2'h3
    |=> cur_ff.op_refused && cur_ff.flags[`BIT_EXEC])
    else $error("chip erase not refused");

  a_guard_chip: assert property (
    op_req && op_mode == 2'h3 && {cur_ff.lock_hi, cur_ff.lock_lo} != 32'hFFFFFFFF
    |=> cur_ff.flags[`BIT_GUARD])
    else $error("chip erase over locked group not flagged");

  a_verdict_pulse: assert property (
    !op_req
    |=> !cur_ff.op_go && !cur_ff.op_refused)
    else $error("verdict without a request");

  a_refuse_flag: assert property (
    cur_ff.op_refused
    |-> (cur_ff.flags & `FLAG_MASK) != 5'h00)
    else $error("refusal without a flag");

  // ----------------------------------------
  // flag and interrupt checks
  // ----------------------------------------
  a_flags_ro: assert property (
    wr_en && paddr == `OFS_IRQ_FLAGS && !op_req
    |=> cur_ff.flags == $past(cur_ff.flags))
    else $error("flag register changed by a write");

  a_clear_exec: assert property (
    wr_en && paddr == `OFS_IRQ_CLR && !pwdata[`BIT_EXEC] && !op_req
    |=> !cur_ff.flags[`BIT_EXEC])
    else $error("executing page flag not cleared");

  a_keep_exec: assert property (
    wr_en && paddr == `OFS_IRQ_CLR && pwdata[`BIT_EXEC] && cur_ff.flags[`BIT_EXEC]
    |=> cur_ff.flags[`BIT_EXEC])
    else $error("writing one cleared the executing page flag");

  a_keep_nonblank: assert property (
    wr_en && paddr == `OFS_IRQ_CLR && pwdata[`BIT_NONBLANK] && cur_ff.flags[`BIT_NONBLANK]
    |=> cur_ff.flags[`BIT_NONBLANK])
    else $error("writing one cleared the programming error flag");

  a_nonblank_irq: assert property (
    cur_ff.flags[`BIT_NONBLANK] && cur_ff.irq_en[`BIT_NONBLANK]
    |=> irq)
    else $error("programming error interrupt missing");

  a_guard_irq: assert property (
    cur_ff.flags[`BIT_GUARD] && cur_ff.irq_en[`BIT_GUARD]
    |=> irq)
    else $error("locked group interrupt missing");

  a_exec_irq: assert property (
    cur_ff.flags[`BIT_EXEC] && cur_ff.irq_en[`BIT_EXEC]
    |=> irq)
    else $error("executing page interrupt missing");

  a_irq_quiet: assert property (
    (cur_ff.flags & cur_ff.irq_en) == 5'h00
    |=> !irq)
    else $error("interrupt without an enabled flag");

endmodule : flash_guard

/* File: verif/flash_array_model.sv */
module flash_array_model (
  // clock
  input wire logic mclk,
  // command from bench
  input wire logic go,
  input wire logic [1:0] mode,
  input wire logic [8:0] page,
  input wire logic [31:0] wdata,
  // request to guard
  output logic op_req,
  output logic [1:0] op_mode,
  output logic [8:0] op_page,
  output logic [31:0] cur_word,
  // verdict from guard
  input wire logic op_go
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [512];
  logic [31:0] pend;
  logic [31:0] ld;
  logic [8:0] lp;
  logic [1:0] lm;
  logic init_done = 1'b0;
  // word only valid with a request; scrambled otherwise
  always @(posedge mclk) begin
    // array starts erased on the first edge
    if (!init_done) begin
      foreach (mem[i]) mem[i] <= 32'hFFFFFFFF;
      init_done <= 1'b1;
    end
    op_req <= go;
    op_mode <= mode;
    op_page <= page;
    pend <= wdata;
    cur_word <= go ? mem[page] : ~mem[page];
    if (op_req) begin
      lm <= op_mode;
      lp <= op_page;
      ld <= pend;
    end
    if (op_go && lm == 2'b01) mem[lp] <= ld;
    if (op_go && lm == 2'b10) mem[lp] <= 32'hFFFFFFFF;
    if (op_go && lm == 2'b11) foreach (mem[i]) mem[i] <= 32'hFFFFFFFF;
  end
endmodule : flash_array_model

/* File: verif/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, lk, en, ef, w, old;
  logic go = 1'b0, op_req, op_go, op_refused, irq;
  logic [1:0] mode = 2'h0, op_mode, m;
  logic [8:0] page = 9'h0, op_page, exec_page = 9'h0, p, e;
  logic [31:0] wdata = 32'h0, cur_word;
  int fail_count = 0, cmp_count = 0, n;
  always #20 mclk = ~mclk;
  flash_guard DUT (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_req(op_req), .op_mode(op_mode), .op_page(op_page),
    .exec_page(exec_page), .cur_word(cur_word), .op_go(op_go), .op_refused(op_refused),
    .irq(irq));
  flash_array_model u_arr (.mclk(mclk), .go(go), .mode(mode), .page(page), .wdata(wdata),
    .op_req(op_req), .op_mode(op_mode), .op_page(op_page), .cur_word(cur_word),
    .op_go(op_go));
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      conclude();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  // ----------------------------------------
  // expected flags of one operation
  // ----------------------------------------
  function automatic logic [31:0] exp_flags(input logic [1:0] md, input logic [8:0] pg,
      input logic [8:0] ep, input logic [31:0] cw, input logic [31:0] lks);
    logic [31:0] f;
    f = 32'h0;
    if (md != 2'b00) begin
      f[0] = (pg == ep) || (md == 2'b11);
      f[1] = (md == 2'b11) ? (lks != 32'hFFFFFFFF) : (pg[8] && !lks[pg[7:3]]);
      f[4] = (md == 2'b01) && (cw != 32'hFFFFFFFF);
    end
    return f;
  endfunction : exp_flags
  initial begin
    void'($urandom(32'h0903));
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'h10 + 8'(i * 4), 32'h0);
      check({31'h0, err}, {31'h0, i == 2 || i == 3});
      check(r, (i == 6) ? 32'h1F : 32'h0);
    end
    apb(1'b1, 8'h10, 32'h1234FFFF);
    apb(1'b0, 8'h10, 32'h0);
    check(r, 32'h0);
    apb(1'b1, 8'h14, 32'hA5A5FFFF);
    apb(1'b0, 8'h14, 32'h0);
    check(r, 32'h0);
    for (int i = 0; i < 60; i++) begin
      lk = $urandom | ((i % 2) ? 32'h0 : $urandom);
      en = $urandom & 32'h13;
      apb(1'b1, 8'h10, {16'h5A5A, lk[15:0]});
      apb(1'b1, 8'h14, {16'h5A5A, lk[31:16]});
      apb(1'b0, 8'h14, 32'h0);
      check(r, {16'h0, lk[31:16]});
      apb(1'b1, 8'h20, en);
      apb(1'b0, 8'h20, 32'h0);
      check(r, en);
      m = 2'($urandom);
      p = 9'($urandom);
      e = $urandom_range(1) ? p : 9'($urandom);
      w = $urandom;
      old = u_arr.mem[p];
      ef = exp_flags(m, p, e, old, lk);
      exec_page <= e;
      mode <= m;
      page <= p;
      wdata <= w;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (!(op_go | op_refused) && n < 5);
      if (!(op_go | op_refused)) begin
        fail_count++;
        conclude();
      end
      check({30'h0, op_go, op_refused}, {30'h0, ~|ef, |ef});
      @(posedge mclk);
      check({31'h0, irq}, {31'h0, |(ef & en)});
      check(u_arr.mem[p], (|ef || m == 2'b00) ? old : (m == 2'b01 ? w : 32'hFFFFFFFF));
      apb(1'b1, 8'h24, 32'h0);
      apb(1'b0, 8'h24, 32'h0);
      check(r, ef);
      apb(1'b1, 8'h28, 32'h1F);
      apb(1'b0, 8'h24, 32'h0);
      check(r, ef);
      apb(1'b0, 8'h28, 32'h0);
      check(r, 32'h1F);
      apb(1'b1, 8'h28, 32'h0);
      apb(1'b0, 8'h24, 32'h0);
      check(r, 32'h0);
      check({31'h0, irq}, 32'h0);
    end
    conclude();
  end
endmodule : tb_top
